// File: core/evt_timer_pkg.sv
/*
  Constants shared by the 16-bit event/square/one-shot timer channel.
  Assumes a single core clock and an Avalon-MM slave register window.
*/
// Function
// - event counter mode counts each qualified edge on the event input
// - event mode: counter equal to compare zero clears and pulses irq zero
// - edge select field at bits 4 and 5 picks rising, falling or both
// - event input sampled at core clock over four, two equal samples
// - channels 0 to 3 lose the output pin in event counter mode
// - output enable plus toggle-on-zero toggles output on compare zero
// - square mode clears and restarts counter on compare zero match
// - output control holds initial level bits and toggle-on-one bit
// - one-shot exists only on channels 0, 1, 4 and 5
// - writing trigger bit 6 clears and starts counter for one pulse
// - counter keeps running after pulse until run bits written 00
// - channels 4 and 5: trigger pin edge clears, starts, fires pulse
// - trigger edges during an active pulse are ignored
// - one-shot uses both compares, output enabled, toggles on both
// - stopped channel ignores both input pins
// - first match after start may come one count clock late
package evt_timer_pkg;
  localparam logic [2:0] ADDR_MODE    = 3'h0;
  localparam logic [2:0] ADDR_CCC     = 3'h1;
  localparam logic [2:0] ADDR_OUTC    = 3'h2;
  localparam logic [2:0] ADDR_PRESC   = 3'h3;
  localparam logic [2:0] ADDR_CMP0    = 3'h4;
  localparam logic [2:0] ADDR_CMP1    = 3'h5;
  localparam logic [2:0] ADDR_COUNT   = 3'h6;
  localparam logic [2:0] ADDR_STATUS  = 3'h7;
  localparam int          ADDR_LSB    = 2;
  // mode control fields
  localparam int          MODE_OVF    = 0;
  localparam int          MODE_RUN_LO = 2;
  localparam int          MODE_RUN_HI = 3;
  localparam logic [1:0] RUN_STOP     = 2'h0;
  localparam logic [1:0] RUN_TRIG     = 2'h1;
  localparam logic [1:0] RUN_FREE     = 2'h2;
  localparam logic [1:0] RUN_MATCH    = 2'h3;
  // output control fields
  localparam int          OC_OE       = 0;
  localparam int          OC_TOG0     = 1;
  localparam int          OC_LVR      = 2;
  localparam int          OC_LVS      = 3;
  localparam int          OC_TOG1     = 4;
  localparam int          OC_OSPE     = 5;
  localparam int          OC_OSPT     = 6;
  // prescaler fields
  localparam int          PR_CLK_LO   = 0;
  localparam int          PR_ES_LO    = 4;
  localparam logic [1:0] PR_CLK_EVT   = 2'h3;
  localparam logic [1:0] ES_FALL      = 2'h0;
  localparam logic [1:0] ES_RISE      = 2'h1;
  localparam logic [1:0] ES_BOTH      = 2'h3;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam int          SAMPLE_DIV  = 4;
endpackage : evt_timer_pkg

// File: core/evt_edge_filter.sv
/*
  Noise filter and edge qualifier for one timer input pin.
  Assumes the pin has already passed a two-flop synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module evt_edge_filter
  import evt_timer_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable,
  input  wire logic       i_sample,
  input  wire logic       i_pin_sync,
  input  wire logic [1:0] i_edge_sel,
  output logic            o_edge
);
  logic       smp_reg, smp_next;
  logic       lvl_reg, lvl_next;
  logic       edge_reg, edge_next;

  always_comb begin
    smp_next  = smp_reg;
    lvl_next  = lvl_reg;
    edge_next = 1'b0;
    if (!i_enable) begin
      smp_next = i_pin_sync;
      lvl_next = i_pin_sync;
    end else if (i_sample) begin
      smp_next = i_pin_sync;
      if (smp_reg == i_pin_sync && i_pin_sync != lvl_reg) begin
        lvl_next = i_pin_sync;
        case (i_edge_sel)
          ES_FALL: edge_next = !i_pin_sync;
          ES_RISE: edge_next = i_pin_sync;
          ES_BOTH: edge_next = 1'b1;
          default: edge_next = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      smp_reg  <= 1'b0;
      lvl_reg  <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      smp_reg  <= smp_next;
      lvl_reg  <= lvl_next;
      edge_reg <= edge_next;
    end
  end

  assign o_edge = edge_reg;
endmodule : evt_edge_filter
`default_nettype wire

// File: core/evt_timer.sv
/*
  One 16-bit timer channel: event counter, square wave, one-shot pulse.
  Assumes an Avalon-MM master on the core clock; pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module evt_timer
  import evt_timer_pkg::*;
#(
  parameter int CHANNEL = 4
)(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [1:0]       o_avs_response,
  input  wire logic        i_event_input_pin,
  input  wire logic        i_trigger_input_pin,
  output logic             o_timer_output_pin,
  output logic             o_timer_output_en,
  output logic             o_match_irq_zero,
  output logic             o_match_irq_one
);
  import evt_timer_pkg::*;

  localparam logic HAS_OSP  = (CHANNEL == 0) || (CHANNEL == 1) ||
                              (CHANNEL == 4) || (CHANNEL == 5);
  localparam logic HAS_XTRG = (CHANNEL == 4) || (CHANNEL == 5);
  localparam logic NO_OUT_EVT = (CHANNEL < 4);

  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] wd,
                                            input logic       be);
    merge_byte = be ? wd : old;
  endfunction : merge_byte

  // synchronisers: first stage read only by the second
  logic [1:0] evt_sync_reg, evt_sync_next;
  logic [1:0] trg_sync_reg, trg_sync_next;

  logic [7:0]  mode_reg, mode_next;
  logic [7:0]  ccc_reg, ccc_next;
  logic [7:0]  outc_reg, outc_next;
  logic [7:0]  presc_reg, presc_next;
  logic [15:0] cmp0_reg, cmp0_next;
  logic [15:0] cmp1_reg, cmp1_next;
  logic [15:0] count_reg, count_next;
  logic [3:0]  pdiv_reg, pdiv_next;
  logic [1:0]  sdiv_reg, sdiv_next;
  logic        ff_reg, ff_next;
  logic        pulse_reg, pulse_next;
  logic        irq0_reg, irq0_next;
  logic        irq1_reg, irq1_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  resp_reg, resp_next;

  logic [1:0] run_mode;
  logic       running;
  logic       evt_mode;
  logic       sample_tick;
  logic       evt_edge;
  logic       trg_edge;
  logic       tick;
  logic       m0;
  logic       m1;
  logic       req;
  logic       wr_hit;
  logic [2:0] idx;
  logic       mapped;

  assign run_mode = mode_reg[MODE_RUN_HI:MODE_RUN_LO];
  assign running  = (run_mode != RUN_STOP);
  assign evt_mode = (presc_reg[PR_CLK_LO +: 2] == PR_CLK_EVT);
  assign sample_tick = (sdiv_reg == 2'(SAMPLE_DIV - 1));
  assign req      = (i_avs_read || i_avs_write) && !ack_reg;
  assign idx      = i_avs_address[ADDR_LSB +: 3];
  assign mapped   = (i_avs_address[1:0] == 2'h0);
  assign wr_hit   = req && i_avs_write && mapped;

  evt_edge_filter u_evt_filt (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_enable   (running),
    .i_sample   (sample_tick),
    .i_pin_sync (evt_sync_reg[1]),
    .i_edge_sel (presc_reg[PR_ES_LO +: 2]),
    .o_edge     (evt_edge)
  );

  evt_edge_filter u_trg_filt (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_enable   (running && HAS_XTRG),
    .i_sample   (sample_tick),
    .i_pin_sync (trg_sync_reg[1]),
    .i_edge_sel (presc_reg[PR_ES_LO +: 2]),
    .o_edge     (trg_edge)
  );

  // count clock: prescaled core clock or qualified event edges
  always_comb begin
    pdiv_next = pdiv_reg + 4'h1;
    sdiv_next = sdiv_reg + 2'h1;
    case (presc_reg[PR_CLK_LO +: 2])
      2'h0:    tick = 1'b1;
      2'h1:    tick = (pdiv_reg[1:0] == 2'h3);
      2'h2:    tick = (pdiv_reg == 4'hF);
      default: tick = evt_edge;
    endcase
    if (!running) begin
      pdiv_next = 4'h0;
    end
  end

  // no match while stopped: count parks at zero and may equal a compare
  assign m0 = tick && running && (count_reg == cmp0_reg);
  assign m1 = tick && running && (count_reg == cmp1_reg);

  // counter, output flop, one-shot state
  always_comb begin
    logic start;
    logic osp;
    logic w_outc;
    logic [7:0] wb;
    start       = 1'b0;
    osp         = HAS_OSP && outc_reg[OC_OSPE];
    w_outc      = wr_hit && (idx == ADDR_OUTC) && i_avs_byteenable[0];
    wb          = i_avs_writedata[7:0];
    count_next  = count_reg;
    ff_next     = ff_reg;
    pulse_next  = pulse_reg;
    irq0_next   = m0;
    irq1_next   = m1;
    if (w_outc && wb[OC_OSPT] && osp && running) begin
      start = 1'b1;
    end
    if (run_mode == RUN_TRIG && osp && trg_edge && !pulse_reg) begin
      start = 1'b1;
    end
    if (!running) begin
      count_next = RESET_WORD;
      pulse_next = 1'b0;
    end else if (start) begin
      count_next = RESET_WORD;
      pulse_next = 1'b1;
    end else if (tick) begin
      if (m0 && (run_mode == RUN_MATCH || evt_mode)) begin
        count_next = RESET_WORD;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
    if (osp) begin
      // pulse rises at first match, falls at second
      if (pulse_reg && !start && (m0 || m1)) begin
        if (m0 && m1) begin
          pulse_next = 1'b0;
        end else begin
          ff_next = !ff_reg;
          if (ff_reg != outc_reg[OC_LVS]) begin
            pulse_next = 1'b0;
          end
        end
      end
    end else begin
      if (m0 && outc_reg[OC_OE] && outc_reg[OC_TOG0]) begin
        ff_next = !ff_reg;
      end else if (m1 && outc_reg[OC_OE] && outc_reg[OC_TOG1]) begin
        ff_next = !ff_reg;
      end
    end
    if (w_outc && !running) begin
      if (wb[OC_LVS] && !wb[OC_LVR]) ff_next = 1'b1;
      else if (wb[OC_LVR] && !wb[OC_LVS]) ff_next = 1'b0;
    end
  end

  // register file and bus answer
  always_comb begin
    logic ovf_set;
    ovf_set    = tick && running && (count_reg == COUNT_MAX);
    mode_next  = mode_reg;
    ccc_next   = ccc_reg;
    outc_next  = outc_reg;
    presc_next = presc_reg;
    cmp0_next  = cmp0_reg;
    cmp1_next  = cmp1_reg;
    ack_next   = req;
    rdata_next = rdata_reg;
    resp_next  = resp_reg;
    if (req) begin
      resp_next = mapped ? 2'h0 : 2'h2;
    end
    if (wr_hit) begin
      case (idx)
        ADDR_MODE:   mode_next  = merge_byte(mode_reg,
                                  i_avs_writedata[7:0], i_avs_byteenable[0]);
        ADDR_CCC:    ccc_next   = merge_byte(ccc_reg,
                                  i_avs_writedata[7:0], i_avs_byteenable[0]);
        ADDR_OUTC:   outc_next  = merge_byte(outc_reg,
                                  i_avs_writedata[7:0], i_avs_byteenable[0]);
        ADDR_PRESC:  presc_next = merge_byte(presc_reg,
                                  i_avs_writedata[7:0], i_avs_byteenable[0]);
        ADDR_CMP0: begin
          cmp0_next[7:0]  = merge_byte(cmp0_reg[7:0],
                            i_avs_writedata[7:0], i_avs_byteenable[0]);
          cmp0_next[15:8] = merge_byte(cmp0_reg[15:8],
                            i_avs_writedata[15:8], i_avs_byteenable[1]);
        end
        ADDR_CMP1: begin
          cmp1_next[7:0]  = merge_byte(cmp1_reg[7:0],
                            i_avs_writedata[7:0], i_avs_byteenable[0]);
          cmp1_next[15:8] = merge_byte(cmp1_reg[15:8],
                            i_avs_writedata[15:8], i_avs_byteenable[1]);
        end
        default: ;
      endcase
    end
    outc_next[OC_OSPT] = 1'b0;
    if (!HAS_OSP) outc_next[OC_OSPE] = 1'b0;
    if (ovf_set) mode_next[MODE_OVF] = 1'b1; // set wins over clear
    if (req && i_avs_read) begin
      case (idx)
        ADDR_MODE:   rdata_next = {24'h00_0000, mode_reg};
        ADDR_CCC:    rdata_next = {24'h00_0000, ccc_reg};
        ADDR_OUTC:   rdata_next = {24'h00_0000, outc_reg};
        ADDR_PRESC:  rdata_next = {24'h00_0000, presc_reg};
        ADDR_CMP0:   rdata_next = {16'h0000, cmp0_reg};
        ADDR_CMP1:   rdata_next = {16'h0000, cmp1_reg};
        ADDR_COUNT:  rdata_next = {16'h0000, count_reg};
        ADDR_STATUS: rdata_next = {30'h0000_0000, pulse_reg, ff_reg};
        default:     rdata_next = 32'h0000_0000;
      endcase
      if (!mapped) rdata_next = 32'h0000_0000;
    end
  end

  always_comb begin
    evt_sync_next = {evt_sync_reg[0], i_event_input_pin};
    trg_sync_next = {trg_sync_reg[0], i_trigger_input_pin};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      evt_sync_reg <= 2'h0;
      trg_sync_reg <= 2'h0;
      mode_reg     <= RESET_BYTE;
      ccc_reg      <= RESET_BYTE;
      outc_reg     <= RESET_BYTE;
      presc_reg    <= RESET_BYTE;
      cmp0_reg     <= RESET_WORD;
      cmp1_reg     <= RESET_WORD;
      count_reg    <= RESET_WORD;
      pdiv_reg     <= 4'h0;
      sdiv_reg     <= 2'h0;
      ff_reg       <= 1'b0;
      pulse_reg    <= 1'b0;
      irq0_reg     <= 1'b0;
      irq1_reg     <= 1'b0;
      ack_reg      <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      resp_reg     <= 2'h0;
    end else begin
      evt_sync_reg <= evt_sync_next;
      trg_sync_reg <= trg_sync_next;
      mode_reg     <= mode_next;
      ccc_reg      <= ccc_next;
      outc_reg     <= outc_next;
      presc_reg    <= presc_next;
      cmp0_reg     <= cmp0_next;
      cmp1_reg     <= cmp1_next;
      count_reg    <= count_next;
      pdiv_reg     <= pdiv_next;
      sdiv_reg     <= sdiv_next;
      ff_reg       <= ff_next;
      pulse_reg    <= pulse_next;
      irq0_reg     <= irq0_next;
      irq1_reg     <= irq1_next;
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
      resp_reg     <= resp_next;
    end
  end

  assign o_avs_waitrequest  = (i_avs_read || i_avs_write) && !ack_reg;
  assign o_avs_readdata     = rdata_reg;
  assign o_avs_response     = resp_reg;
  assign o_timer_output_pin = ff_reg;
  assign o_timer_output_en  = outc_reg[OC_OE] &&
                              !(NO_OUT_EVT && evt_mode);
  assign o_match_irq_zero   = irq0_reg;
  assign o_match_irq_one    = irq1_reg;
endmodule : evt_timer
`default_nettype wire

// File: testbench/evt_pin_model.sv
/* Far side of the timer: event and trigger sources, output pin watcher.
   Assumes the bench calls its tasks from the core clock domain. */
`timescale 1ns/1ps
`default_nettype none
module evt_pin_model (
  input  wire logic i_core_clk,
  input  wire logic i_timer_output_pin,
  input  wire logic i_timer_output_en,
  output logic      o_event_input_pin,
  output logic      o_trigger_input_pin
);
  int   out_edges = 0;
  logic last_out  = 1'b0;
  initial begin
    o_event_input_pin = 1'b0;
    o_trigger_input_pin = 1'b0;
  end
  // count pin changes only while the pin is driven
  always @(posedge i_core_clk) begin
    if (i_timer_output_en === 1'b1 && i_timer_output_pin !== last_out)
      out_edges++;
    last_out <= i_timer_output_pin;
  end
  // each level held long enough for several fxx/4 samples
  task automatic ev_toggle(input int n, input logic trig);
    repeat (n) begin
      @(posedge i_core_clk);
      if (trig)
        o_trigger_input_pin <= !o_trigger_input_pin;
      else
        o_event_input_pin <= !o_event_input_pin;
      repeat (16) @(posedge i_core_clk);
    end
  endtask : ev_toggle
  // one-cycle spike, never seen on two samples
  task automatic glitch();
    @(posedge i_core_clk);
    o_event_input_pin <= !o_event_input_pin;
    @(posedge i_core_clk);
    o_event_input_pin <= !o_event_input_pin;
  endtask : glitch
endmodule : evt_pin_model
`default_nettype wire

// File: testbench/evt_timer_chk.sv
/* Port checker for evt_timer: bus handshake, irq pulses, stopped quiet.
   Bound to every evt_timer instance; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module evt_timer_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [1:0]  o_avs_response,
  input wire logic        o_timer_output_en,
  input wire logic        o_match_irq_zero,
  input wire logic        o_match_irq_one
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic       req;
  logic       rd_ok;
  logic [1:0] run_q;
  logic [1:0] idle_q;
  assign req   = i_avs_read || i_avs_write;
  assign rd_ok = i_avs_read && !o_avs_waitrequest;
  // run bits as taken by the slave, and cycles spent stopped
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      run_q  <= 2'h0;
      idle_q <= 2'h0;
    end else begin
      if (i_avs_write && o_avs_waitrequest && i_avs_address == 5'h00)
        run_q <= i_avs_writedata[3:2];
      if (run_q != 2'h0)
        idle_q <= 2'h0;
      else if (idle_q != 2'h3)
        idle_q <= idle_q + 2'h1;
    end
  end
  property p_wait_idle; !req |-> !o_avs_waitrequest; endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest without request");
  property p_wait_ack; req && o_avs_waitrequest ##1 req |-> !o_avs_waitrequest;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("no answer");
  property p_irq0_pulse; o_match_irq_zero |=> !o_match_irq_zero; endproperty
  a_irq0_pulse: assert property (p_irq0_pulse)
    else $error("irq zero longer than one cycle");
  property p_irq1_pulse; $rose(o_match_irq_one) |=> $fell(o_match_irq_one);
  endproperty
  a_irq1_pulse: assert property (p_irq1_pulse)
    else $error("irq one longer than one cycle");
  property p_unmapped;
    rd_ok && i_avs_address[1:0] != 2'h0 |->
      o_avs_response == 2'h2 && o_avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_mapped_ok;
    rd_ok && i_avs_address[1:0] == 2'h0 |-> o_avs_response == 2'h0;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("bad response");
  property p_rdata_hold; !$past(i_avs_read) |-> $stable(o_avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("readdata moved");
  property p_oe_hold; !$past(i_avs_write) |-> $stable(o_timer_output_en);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output enable moved without write");
  property p_stop_quiet;
    idle_q == 2'h3 |-> !o_match_irq_zero && !o_match_irq_one;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("match while stopped");
  c_irq0: cover property (o_match_irq_zero);
  c_irq1: cover property (o_match_irq_one);
  c_slverr: cover property (rd_ok && o_avs_response == 2'h2);
endmodule : evt_timer_chk
bind evt_timer evt_timer_chk u_chk (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
  .o_timer_output_en(o_timer_output_en),
  .o_match_irq_zero(o_match_irq_zero), .o_match_irq_one(o_match_irq_one));
`default_nettype wire

// File: testbench/evt_timer_tb.sv
/* Self-checking bench for evt_timer with a counting reference model.
   Assumes evt_pin_model on the pins and a 25 MHz core clock. */
`timescale 1ns/1ps
`default_nettype none
module evt_timer_tb;
  import evt_timer_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rdata;
  logic [1:0]  resp;
  logic        wreq, pin, oe, irq0, irq1, ev, tr;
  logic [1:0]  esl [3] = '{ES_RISE, ES_FALL, ES_BOTH};
  int          fails = 0;
  int          checks_done = 0;
  int          n_irq0 = 0;
  int          hi_cyc = 0;
  int          hi_w = 0;
  evt_timer #(.CHANNEL(4)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_avs_response(resp),
    .i_event_input_pin(ev), .i_trigger_input_pin(tr),
    .o_timer_output_pin(pin), .o_timer_output_en(oe),
    .o_match_irq_zero(irq0), .o_match_irq_one(irq1));
  evt_pin_model pm (.i_core_clk(i_core_clk), .i_timer_output_pin(pin),
    .i_timer_output_en(oe), .o_event_input_pin(ev), .o_trigger_input_pin(tr));
  always #20 i_core_clk = !i_core_clk;
  // irq count and length of the last high stretch of the pin
  always @(posedge i_core_clk) begin
    if (irq0 === 1'b1)
      n_irq0++;
    if (pin === 1'b1)
      hi_cyc++;
    else if (hi_cyc != 0) begin
      hi_w = hi_cyc;
      hi_cyc = 0;
    end
  end
  function automatic logic [4:0] ad(input logic [2:0] x);
    return {x, 2'h0};
  endfunction : ad
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk_w
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge i_core_clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    for (k = 0; k < 50; k++) begin
      @(posedge i_core_clk);
      if (wreq === 1'b0)
        break;
    end
    if (k == 50) begin
      fails++;
      $display("[ERR] %0t bus hang", $time);
      give_verdict();
    end
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  initial begin
    int c0, ex, k, n, w, t;
    logic [31:0] v;
    void'($urandom(50));
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      bus(1'b0, ad(3'(k)), 32'h0000_0000);
      chk_w(rdat, 32'h0000_0000);
    end
    bus(1'b0, 5'h05, 32'h0000_0000);
    chk_w({rdat[29:0], resp}, 32'h0000_0002);
    $display("test reset done");
    c0 = 5 + int'($urandom % 4);
    bus(1'b1, ad(ADDR_CMP0), 32'(c0));
    foreach (esl[i]) begin
      bus(1'b1, ad(ADDR_MODE), 32'h0000_0000);
      bus(1'b1, ad(ADDR_PRESC), {26'h0, esl[i], 2'h0, PR_CLK_EVT});
      bus(1'b0, ad(ADDR_COUNT), 32'h0000_0000);
      v = rdat;
      pm.ev_toggle(1, 1'b0);
      bus(1'b0, ad(ADDR_COUNT), 32'h0000_0000);
      chk_w(rdat, v);
      bus(1'b1, ad(ADDR_MODE), {28'h0, RUN_MATCH, 2'h0});
      bus(1'b0, ad(ADDR_COUNT), 32'h0000_0000);
      ex = int'(rdat[15:0]);
      n = n_irq0;
      w = 0;
      for (k = 0; k < 2 * c0 + 1; k++) begin
        pm.ev_toggle(1, 1'b0);
        if (esl[i] == ES_BOTH || (esl[i] == ES_RISE) == (ev === 1'b1)) begin
          if (ex == c0) begin
            ex = 0;
            w++;
          end else begin
            ex++;
          end
        end
      end
      pm.glitch();
      repeat (16) @(posedge i_core_clk);
      bus(1'b0, ad(ADDR_COUNT), 32'h0000_0000);
      chk_w(rdat, 32'(ex));
      chk_w(32'(n_irq0 - n), 32'(w));
    end
    $display("test event done");
    bus(1'b1, ad(ADDR_MODE), 32'h0000_0000);
    bus(1'b1, ad(ADDR_PRESC), 32'h0000_0000);
    c0 = 3 + int'($urandom % 8);
    bus(1'b1, ad(ADDR_CMP0), 32'(c0));
    bus(1'b1, ad(ADDR_CMP1), 32'h0000_0001);
    bus(1'b1, ad(ADDR_OUTC), 32'h0000_000B);
    bus(1'b0, ad(ADDR_STATUS), 32'h0000_0000);
    chk_w(rdat & 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, ad(ADDR_OUTC), 32'h0000_0007);
    bus(1'b0, ad(ADDR_STATUS), 32'h0000_0000);
    chk_w(rdat & 32'h0000_0001, 32'h0000_0000);
    hi_w = 0;
    bus(1'b1, ad(ADDR_MODE), {28'h0, RUN_MATCH, 2'h0});
    repeat (6 * c0 + 12) @(posedge i_core_clk);
    chk_w(32'(hi_w), 32'(c0 + 1));
    $display("test square done");
    for (k = 0; k < 2; k++) begin
      n = 4 + int'($urandom % 10);
      w = n + 5 + int'($urandom % 10);
      bus(1'b1, ad(ADDR_MODE), 32'h0000_0000);
      bus(1'b1, ad(ADDR_CMP1), 32'(k ? w : n));
      bus(1'b1, ad(ADDR_CMP0), 32'(k ? n : w));
      bus(1'b1, ad(ADDR_OUTC), 32'h0000_0037);
      bus(1'b1, ad(ADDR_MODE), {28'h0, RUN_FREE, 2'h0});
      t = pm.out_edges;
      hi_w = 0;
      bus(1'b1, ad(ADDR_OUTC), 32'h0000_0073);
      repeat (w + 40) @(posedge i_core_clk);
      chk_w(32'(hi_w), 32'(w - n));
      chk_w(32'(pm.out_edges - t), 32'h0000_0002);
      bus(1'b0, ad(ADDR_COUNT), 32'h0000_0000);
      v = rdat;
      bus(1'b0, ad(ADDR_COUNT), 32'h0000_0000);
      chk_w(32'(rdat != v), 32'h0000_0001);
    end
    $display("test software one-shot done");
    bus(1'b1, ad(ADDR_MODE), 32'h0000_0000);
    bus(1'b1, ad(ADDR_PRESC), {26'h0, ES_RISE, 4'h0});
    bus(1'b1, ad(ADDR_CMP1), 32'h0000_0014);
    bus(1'b1, ad(ADDR_CMP0), 32'h0000_0096);
    bus(1'b1, ad(ADDR_OUTC), 32'h0000_0037);
    bus(1'b1, ad(ADDR_MODE), {28'h0, RUN_TRIG, 2'h0});
    t = pm.out_edges;
    hi_w = 0;
    pm.ev_toggle(3, 1'b1);
    repeat (200) @(posedge i_core_clk);
    chk_w(32'(hi_w), 32'h0000_0082);
    chk_w(32'(pm.out_edges - t), 32'h0000_0002);
    $display("test trigger one-shot done");
    give_verdict();
  end
endmodule : evt_timer_tb
`default_nettype wire
